// >>> rfsp_regs.svh
// Frame layout and timing constants of the serial control port
`ifndef RFSP_REGS_SVH
`define RFSP_REGS_SVH

// ==================================================
// Frame layout, most significant bit first
`define RFSP_ADDR_W 11
`define RFSP_DATA_W 8
`define RFSP_HDR_W 5
`define RFSP_FRAME_W 24
`define RFSP_CNT_W 5
`define RFSP_SIZE_W 4
`define RFSP_DIR_READ 1'b1
`define RFSP_SIZE_ONE 4'h0

// ==================================================
// Bit counts at which each field completes
`define RFSP_HDR_LAST 5'h04
`define RFSP_ADDR_LAST 5'h0f
`define RFSP_FRAME_LAST 5'h17
`define RFSP_ZERO_CNT 5'h00

// ==================================================
// Serial clock from the host, derived from ref_clk
`define RFSP_CLK_NS 4
`define RFSP_SCLK_HALF_NS 32
`define RFSP_SCLK_HALF ((`RFSP_SCLK_HALF_NS) / (`RFSP_CLK_NS))
`define RFSP_DIV_W 4

`endif

// >>> rfsp_pkg.sv
// Types shared by both ends of the serial control port
package rfsp_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_HEADER,
    DEV_ADDRESS,
    DEV_DATA,
    DEV_DONE
  } rfsp_dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_SHIFT,
    HOST_END,
    HOST_GAP
  } rfsp_host_state_t;

endpackage : rfsp_pkg

// >>> rfsp_link_if.sv
// Pins between the baseband processor and the receiver control port
`timescale 1ns/10ps
`default_nettype none

interface rfsp_link_if;
  // Driven by the host
  logic sclk;
  logic chipSelN;
  logic sdiLine;
  logic sdioHostOut;
  logic sdioHostOeN;
  // Driven by the device
  logic serialReturnOut;
  logic serialReturnOeN;
  logic sdioDevOut;
  logic sdioDevOeN;
  // Resolved wire levels, pulled up when nobody drives
  logic sdioLine;
  logic serialReturnLine;

  assign sdioLine = !sdioHostOeN ? sdioHostOut : (!sdioDevOeN ? sdioDevOut : 1'b1);
  assign serialReturnLine = !serialReturnOeN ? serialReturnOut : 1'b1;

  modport host (
    output sclk, chipSelN, sdiLine, sdioHostOut, sdioHostOeN,
    input sdioLine, serialReturnLine
  );

  modport device (
    input sclk, chipSelN, sdiLine, sdioLine,
    output serialReturnOut, serialReturnOeN, sdioDevOut, sdioDevOeN
  );
endinterface : rfsp_link_if

`default_nettype wire

// >>> rfsp_device.sv
// Device end of the receiver serial control port
`timescale 1ns/10ps
`default_nettype none
`include "rfsp_regs.svh"

// How it works
// R1: Four-wire mode: separate in and return lines
// R2: Three-wire mode: one shared bidirectional data line
// R3: Every frame is exactly twenty-four bits
// R4: First five bits: direction and byte count
// R5: Next eleven bits: register address
// R6: Write: last eight bits stored at address
// R7: Read: host drives sixteen bits first
// R8: Read: eight bits returned on selected line
// R9: All configuration reachable through this port
// R10: Low chip select frames, MSB first, tristate
module rfsp_device import rfsp_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Mode select
  input wire logic threeWire,
  // Serial link
  rfsp_link_if.device link,
  // Register space access
  output logic regWrite,
  output logic regRead,
  output logic [`RFSP_ADDR_W-1:0] regAddr,
  output logic [`RFSP_DATA_W-1:0] regWrData,
  input wire logic [`RFSP_DATA_W-1:0] regRdData,
  // Status
  output logic frameErr
);

  // ==================================================
  // Pin synchronisers
  logic sclkS1;
  logic sclkS2;
  logic sclkS3;
  logic csS1;
  logic csS2;
  logic csS3;
  logic sdiS1;
  logic sdiS2;
  logic sdioS1;
  logic sdioS2;

  // Pins come from the host's clock tree, so two flops each, plus a third on sclk and chip select for edge detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkS3 <= 1'b0;
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csS3 <= 1'b1;
      sdiS1 <= 1'b0;
      sdiS2 <= 1'b0;
      sdioS1 <= 1'b0;
      sdioS2 <= 1'b0;
    end else begin
      sclkS1 <= link.sclk;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      csS1 <= link.chipSelN;
      csS2 <= csS1;
      csS3 <= csS2;
      sdiS1 <= link.sdiLine;
      sdiS2 <= sdiS1;
      sdioS1 <= link.sdioLine;
      sdioS2 <= sdioS1;
    end
  end

  logic selected;
  logic sclkRise;
  logic sclkFall;
  logic frameEnd;
  logic dataIn;

  assign selected = !csS2; // R10
  assign sclkRise = selected && sclkS2 && !sclkS3; // R10
  assign sclkFall = selected && !sclkS2 && sclkS3;
  assign frameEnd = csS2 && !csS3;
  assign dataIn = threeWire ? sdioS2 : sdiS2; // R1 R2

  // ==================================================
  // Frame sequencing
  rfsp_dev_state_t state;
  logic [`RFSP_CNT_W-1:0] bitCnt;
  logic [`RFSP_ADDR_W+`RFSP_HDR_W-1:0] shiftIn;
  logic isRead;
  logic sizeOk;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= DEV_IDLE;
    end else if (!selected) begin
      state <= DEV_IDLE;
    end else begin
      case (state)
        DEV_IDLE: begin
          state <= DEV_HEADER;
        end
        DEV_HEADER: begin
          if (sclkRise && bitCnt == `RFSP_HDR_LAST) begin
            state <= DEV_ADDRESS; // R4
          end
        end
        DEV_ADDRESS: begin
          if (sclkRise && bitCnt == `RFSP_ADDR_LAST) begin
            state <= DEV_DATA; // R5
          end
        end
        DEV_DATA: begin
          if (sclkRise && bitCnt == `RFSP_FRAME_LAST) begin
            state <= DEV_DONE; // R3
          end
        end
        default: begin
          state <= DEV_DONE;
        end
      endcase
    end
  end

  // Edges past the last bit are ignored until chip select rises
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt <= `RFSP_ZERO_CNT;
    end else if (!selected) begin
      bitCnt <= `RFSP_ZERO_CNT;
    end else if (sclkRise && state != DEV_DONE) begin
      bitCnt <= bitCnt + 5'h01; // R3
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftIn <= '0;
    end else if (sclkRise) begin
      shiftIn <= {shiftIn[`RFSP_ADDR_W+`RFSP_HDR_W-2:0], dataIn}; // R10
    end
  end

  // ==================================================
  // Header decode, before the address arrives
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      isRead <= 1'b0;
      sizeOk <= 1'b0;
    end else if (sclkRise && state == DEV_HEADER && bitCnt == `RFSP_HDR_LAST) begin
      isRead <= shiftIn[`RFSP_SIZE_W-1] == `RFSP_DIR_READ; // R4
      sizeOk <= {shiftIn[`RFSP_SIZE_W-2:0], dataIn} == `RFSP_SIZE_ONE; // R4
    end
  end

  // ==================================================
  // Register space strobes
  logic addrDone;
  logic dataDone;

  assign addrDone = sclkRise && state == DEV_ADDRESS && bitCnt == `RFSP_ADDR_LAST;
  assign dataDone = sclkRise && state == DEV_DATA && bitCnt == `RFSP_FRAME_LAST;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regAddr <= '0;
      regRead <= 1'b0;
    end else begin
      regRead <= addrDone && isRead && sizeOk; // R7 R9
      if (addrDone) begin
        regAddr <= {shiftIn[`RFSP_ADDR_W-2:0], dataIn}; // R5
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regWrite <= 1'b0;
      regWrData <= '0;
    end else begin
      regWrite <= dataDone && !isRead && sizeOk; // R6 R9
      if (dataDone && !isRead) begin
        regWrData <= {shiftIn[`RFSP_DATA_W-2:0], dataIn}; // R6
      end
    end
  end

  // Short frame or unsupported byte count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frameErr <= 1'b0;
    end else begin
      frameErr <= (frameEnd && state != DEV_DONE && state != DEV_IDLE)
        || (dataDone && !sizeOk); // R3
    end
  end

  // ==================================================
  // Read data return
  logic [`RFSP_DATA_W-1:0] rdShift;
  logic sendBit;

  assign sendBit = sclkFall && state == DEV_DATA && isRead && sizeOk;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdShift <= '0;
    end else if (regRead) begin
      rdShift <= regRdData;
    end else if (sendBit) begin
      rdShift <= {rdShift[`RFSP_DATA_W-2:0], 1'b0}; // R8
    end
  end

  // Bits change on the falling edge so the host samples them stable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.serialReturnOut <= 1'b0;
      link.serialReturnOeN <= 1'b1;
      link.sdioDevOut <= 1'b0;
      link.sdioDevOeN <= 1'b1;
    end else if (!selected || (sclkFall && state == DEV_DONE)) begin
      link.serialReturnOeN <= 1'b1; // R10
      link.sdioDevOeN <= 1'b1; // R10
    end else if (sendBit) begin
      if (threeWire) begin
        link.sdioDevOut <= rdShift[`RFSP_DATA_W-1]; // R2 R8
        link.sdioDevOeN <= 1'b0;
      end else begin
        link.serialReturnOut <= rdShift[`RFSP_DATA_W-1]; // R1 R8
        link.serialReturnOeN <= 1'b0;
      end
    end
  end

endmodule : rfsp_device

`default_nettype wire

// >>> rfsp_baseband_host.sv
// Baseband processor end of the receiver serial control port
`timescale 1ns/10ps
`default_nettype none
`include "rfsp_regs.svh"

module rfsp_baseband_host import rfsp_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Request
  input wire logic reqValid,
  input wire logic reqRead,
  input wire logic [`RFSP_ADDR_W-1:0] reqAddr,
  input wire logic [`RFSP_DATA_W-1:0] reqData,
  input wire logic threeWire,
  // Answer
  output logic busy,
  output logic rdValid,
  output logic [`RFSP_DATA_W-1:0] rdData,
  // Serial link
  rfsp_link_if.host link
);

  // ==================================================
  // Returned data synchronisers
  logic sdioS1;
  logic sdioS2;
  logic retS1;
  logic retS2;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdioS1 <= 1'b0;
      sdioS2 <= 1'b0;
      retS1 <= 1'b0;
      retS2 <= 1'b0;
    end else begin
      sdioS1 <= link.sdioLine;
      sdioS2 <= sdioS1;
      retS1 <= link.serialReturnLine;
      retS2 <= retS1;
    end
  end

  // ==================================================
  // Serial clock divider; half period covers the device's sync delay
  rfsp_host_state_t state;
  logic [`RFSP_DIV_W-1:0] divCnt;
  logic tick;
  logic accept;

  assign accept = state == HOST_IDLE && reqValid;
  assign tick = divCnt == `RFSP_DIV_W'(`RFSP_SCLK_HALF - 1);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt <= '0;
    end else if (accept || tick) begin
      divCnt <= '0;
    end else if (state != HOST_IDLE) begin
      divCnt <= divCnt + `RFSP_DIV_W'(1);
    end
  end

  // ==================================================
  // Frame sequencing
  logic [`RFSP_FRAME_W-1:0] frame;
  logic [`RFSP_CNT_W-1:0] bitCnt;
  logic frameRead;
  logic frameThree;
  logic [`RFSP_DATA_W-1:0] rdShift;
  logic rxBit;

  assign rxBit = frameThree ? sdioS2 : retS2;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= HOST_IDLE;
      busy <= 1'b0;
      frame <= '0;
      bitCnt <= `RFSP_ZERO_CNT;
      frameRead <= 1'b0;
      frameThree <= 1'b0;
    end else begin
      case (state)
        HOST_IDLE: begin
          if (reqValid) begin
            state <= HOST_SHIFT;
            busy <= 1'b1;
            frame <= {reqRead, `RFSP_SIZE_ONE, reqAddr, reqData}; // R3 R4 R5
            bitCnt <= `RFSP_ZERO_CNT;
            frameRead <= reqRead;
            frameThree <= threeWire;
          end
        end
        HOST_SHIFT: begin
          if (tick && link.sclk) begin
            if (bitCnt == `RFSP_FRAME_LAST) begin
              state <= HOST_END; // R3
            end else begin
              bitCnt <= bitCnt + 5'h01;
              frame <= {frame[`RFSP_FRAME_W-2:0], 1'b0}; // R10
            end
          end
        end
        HOST_END: begin
          if (tick) begin
            state <= HOST_GAP;
          end
        end
        default: begin
          if (tick) begin
            state <= HOST_IDLE;
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==================================================
  // Pin drivers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.sclk <= 1'b0;
      link.chipSelN <= 1'b1;
      link.sdiLine <= 1'b0;
      link.sdioHostOut <= 1'b0;
      link.sdioHostOeN <= 1'b1;
    end else if (accept) begin
      link.chipSelN <= 1'b0; // R10
      link.sdiLine <= reqRead;
      link.sdioHostOut <= reqRead;
      link.sdioHostOeN <= !threeWire; // R2
    end else if (state == HOST_SHIFT && tick) begin
      link.sclk <= !link.sclk;
      if (link.sclk && bitCnt != `RFSP_FRAME_LAST) begin
        link.sdiLine <= frame[`RFSP_FRAME_W-2]; // R1
        link.sdioHostOut <= frame[`RFSP_FRAME_W-2]; // R2
        if (frameRead && bitCnt == `RFSP_ADDR_LAST) begin
          link.sdioHostOeN <= 1'b1; // R7
        end
      end
    end else if (state == HOST_END && tick) begin
      link.chipSelN <= 1'b1;
      link.sdioHostOeN <= 1'b1;
    end
  end

  // ==================================================
  // Read data capture on the rising serial clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdShift <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      rdValid <= 1'b0;
      if (state == HOST_SHIFT && tick && !link.sclk && frameRead
          && bitCnt > `RFSP_ADDR_LAST) begin
        rdShift <= {rdShift[`RFSP_DATA_W-2:0], rxBit}; // R8
      end
      if (state == HOST_END && tick) begin
        rdValid <= frameRead;
        rdData <= rdShift;
      end
    end
  end

endmodule : rfsp_baseband_host

`default_nettype wire

// >>> rfsp_link_monitor.sv
// Protocol checker on the pins between both ends of the serial control port
`timescale 1ns/10ps
`default_nettype none

module rfsp_link_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host pins
  input wire logic sclk,
  input wire logic chipSelN,
  input wire logic sdiLine,
  input wire logic sdioHostOut,
  input wire logic sdioHostOeN,
  // Device pins
  input wire logic serialReturnOeN,
  input wire logic sdioDevOeN
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // ==================================================
  // Serial clock rises inside the current frame
  logic sclkQ;
  logic [5:0] riseCnt;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkQ <= 1'b0;
    end else begin
      sclkQ <= sclk;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      riseCnt <= 6'h00;
    end else if (chipSelN) begin
      riseCnt <= 6'h00;
    end else if (sclk && !sclkQ) begin
      riseCnt <= riseCnt + 6'h01;
    end
  end

  // ==================================================
  // Framing and timing
  property p_sclk_idle;
    chipSelN |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moved outside a frame");

  property p_cs_setup;
    $fell(chipSelN) |-> !sclk [*8] ##1 sclk;
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("first sclk rise misplaced");

  property p_sclk_high;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high phase not 8 cycles");

  property p_frame_bits;
    $rose(chipSelN) |-> riseCnt == 6'h18;
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame not 24 bits");

  // Host data may only move while sclk is low
  property p_data_steady;
    sclk && $past(sclk) |-> $stable(sdiLine) && $stable(sdioHostOut);
  endproperty
  a_data_steady: assert property (p_data_steady) else $error("data moved in high phase");

  // ==================================================
  // Line ownership
  property p_no_clash;
    !(!sdioHostOeN && !sdioDevOeN);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive shared line");

  property p_dev_window;
    !sdioDevOeN |-> !chipSelN && riseCnt >= 6'h10;
  endproperty
  a_dev_window: assert property (p_dev_window) else $error("device drives shared line early");

  property p_return_window;
    !serialReturnOeN |-> !chipSelN && riseCnt >= 6'h10;
  endproperty
  a_return_window: assert property (p_return_window) else $error("return line driven early");

  property p_host_release;
    $rose(sdioHostOeN) && !chipSelN |-> riseCnt == 6'h10;
  endproperty
  a_host_release: assert property (p_host_release) else $error("host released at wrong bit");

  property p_released;
    chipSelN |-> serialReturnOeN && sdioDevOeN;
  endproperty
  a_released: assert property (p_released) else $error("device drives while deselected");
endmodule : rfsp_link_monitor

`default_nettype wire

// >>> testbench.sv
// Self-checking bench joining host and device ends of the serial control port
`timescale 1ns/10ps
`default_nettype none
`include "rfsp_regs.svh"

module testbench import rfsp_pkg::*;;
  // ==================================================
  // Signals
  logic ref_clk, reset_n, threeWire, reqValid, reqRead, busy, rdValid;
  logic regWrite, regRead, frameErr;
  logic [`RFSP_ADDR_W-1:0] reqAddr, regAddr;
  logic [`RFSP_DATA_W-1:0] reqData, rdData, regWrData, regRdData;
  logic [7:0] mem [0:2047];
  logic [7:0] model [0:2047];
  logic [23:0] inWord, frmQ [$];
  logic [7:0] retWord, rdQ [$];
  logic [18:0] wrQ [$];
  logic [10:0] rdAddrQ [$];
  int fails = 0;
  int nCompared = 0;
  int cycles = 0;

  rfsp_link_if link ();
  rfsp_device rfsp_device_i (.ref_clk, .reset_n, .threeWire, .link, .regWrite, .regRead,
    .regAddr, .regWrData, .regRdData, .frameErr);
  rfsp_baseband_host rfsp_baseband_host_i (.ref_clk, .reset_n, .reqValid, .reqRead, .reqAddr,
    .reqData, .threeWire, .busy, .rdValid, .rdData, .link);
  rfsp_link_monitor rfsp_link_monitor_i (.ref_clk, .reset_n, .sclk(link.sclk),
    .chipSelN(link.chipSelN), .sdiLine(link.sdiLine), .sdioHostOut(link.sdioHostOut),
    .sdioHostOeN(link.sdioHostOeN), .serialReturnOeN(link.serialReturnOeN),
    .sdioDevOeN(link.sdioDevOeN));

  always #2 ref_clk = ~ref_clk;

  // ==================================================
  // Register space behind the device
  assign regRdData = mem[regAddr];
  always @(posedge ref_clk) if (regWrite === 1'b1) mem[regAddr] <= regWrData;

  // ==================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    if (fails == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic xfer(input logic rd, input logic [10:0] a, input logic [7:0] d);
    int n;
    reqValid = 1'b1;
    reqRead = rd;
    reqAddr = a;
    reqData = d;
    frmQ.push_back({rd, `RFSP_SIZE_ONE, a, rd ? model[a] : d});
    if (rd) begin
      rdQ.push_back(model[a]);
      rdAddrQ.push_back(a);
    end else begin
      wrQ.push_back({a, d});
      model[a] = d;
    end
    @(negedge ref_clk);
    check("busy", busy, 1'b1);
    // Second offer while busy, no queue so it must vanish
    reqAddr = ~a;
    reqRead = ~rd;
    @(negedge ref_clk);
    reqValid = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    // A host that never frees counts as a mismatch here
    check("busy end", busy, 1'b0);
  endtask : xfer

  // ==================================================
  // Wire capture, MSB first
  always @(posedge link.sclk) begin
    inWord <= {inWord[22:0], threeWire ? link.sdioLine : link.sdiLine};
    retWord <= {retWord[6:0], link.serialReturnLine};
  end

  always @(posedge link.chipSelN) if (reset_n === 1'b1) begin
    check("frame", (inWord[23] && !threeWire) ? {inWord[23:8], retWord} : inWord,
      frmQ.pop_front());
  end

  // ==================================================
  // Result watcher
  always @(negedge ref_clk) begin
    if (regWrite === 1'b1) check("write", {regAddr, regWrData}, wrQ.pop_front());
    if (regRead === 1'b1) check("read addr", regAddr, rdAddrQ.pop_front());
    if (rdValid === 1'b1) check("read data", rdData, rdQ.pop_front());
    if (frameErr !== 1'b0) check("frame error", frameErr, 1'b0);
    if (link.sdioDevOeN === 1'b0) check("shared line use", threeWire, 1'b1);
    if (link.serialReturnOeN === 1'b0) check("return line use", threeWire, 1'b0);
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      check("timeout", 1, 0);
      summarize();
    end
  end

  // ==================================================
  // Main sequence: both modes, boundary and random addresses
  initial begin
    logic [10:0] a;
    logic [10:0] addrs [12];
    ref_clk = 1'b0;
    reset_n = 1'b0;
    threeWire = 1'b0;
    reqValid = 1'b0;
    reqRead = 1'b0;
    reqAddr = 11'h000;
    reqData = 8'h00;
    void'($urandom(89264));
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int m = 0; m < 2; m++) begin
      threeWire = m[0];
      for (int i = 0; i < 12; i++) begin
        a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($urandom);
        addrs[i] = a;
        xfer(1'b0, a, 8'($urandom));
        if (i % 4 == 3) xfer(1'b1, a, 8'($urandom));
      end
      foreach (addrs[i]) xfer(1'b1, addrs[i], 8'($urandom));
    end
    check("left over", wrQ.size() + rdQ.size() + frmQ.size() + rdAddrQ.size(), 0);
    summarize();
  end
endmodule : testbench

`default_nettype wire
